// ===== src/ilot_decoder.sv
// instruction length, addressing mode and state time decoder
//
// Operation
// - indirect shares opcode; second byte bit0 one means autoincrement
// - indexed shares opcode; odd second byte is long form, one byte more
// - short jump/call offset is three opcode bits plus next byte
// - register file or special register operands use register timings
// - memory-mapped or outside operands use longer memory timings
// - block word move costs 6 plus 8, 11 or 14 per word
// - signed divide takes 26, 27, 28 or 31 state times
// - signed multiply takes 16, 17, 18 or 21 state times
// - word add takes 4, 5, 6 or 8, autoincrement one more
// - unsigned divide takes 24, 25, 26 or 29 state times
// - E1 word and E0 byte decrement-branch are three bytes
// - bit jumps 30-3F three bytes; flag jumps D0-DF two bytes
// - zero-extending byte load takes 4, 4, 5 or 8
// - E3 is short-space or wide-space indirect branch by mode
// - prefix FE adds one byte to the unsigned multiply/divide
`timescale 1ns/100ps
module ilot_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire ilot_pkg::ilot_req_s req,
  output logic rspValid,
  output ilot_pkg::ilot_rsp_s rsp
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ilot_pkg::ilot_state_e st;
    logic valid;
    ilot_pkg::ilot_rsp_s rsp;
  } ilot_regs_s;

  ilot_regs_s state_q;
  ilot_regs_s state_d;

  logic prefixed;
  logic [7:0] core;
  logic [7:0] modeByte;
  logic [10:0] offset;
  logic shortRel;

  // strip the signed prefix so the unsigned opcode drives decoding
  assign prefixed = (req.op == ilot_pkg::OP_PREFIX);
  assign core = prefixed ? req.b1 : req.op;
  assign modeByte = prefixed ? req.b2 : req.b1;
  assign shortRel = (core[7:4] == ilot_pkg::OP_SHORT_RELATIVE_JUMP_LO[7:4]);

  ilot_offset i_ilot_offset (
    .op(core),
    .disp(req.b1),
    .isShort(shortRel),
    .offset(offset)
  );

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  // mode from low opcode bits and second-byte bit0
  function automatic ilot_pkg::ilot_mode_e modeOf(
    input logic [1:0] sel,
    input logic lsb
  );
    unique case (sel)
      2'b00: modeOf = ilot_pkg::ILOT_MODE_DIRECT;
      2'b01: modeOf = ilot_pkg::ILOT_MODE_IMMED;
      2'b10: modeOf = lsb ? ilot_pkg::ILOT_MODE_IND_AUTO
                          : ilot_pkg::ILOT_MODE_IND;
      2'b11: modeOf = lsb ? ilot_pkg::ILOT_MODE_IDX_L
                          : ilot_pkg::ILOT_MODE_IDX_S;
    endcase
  endfunction : modeOf

  // time from a direct base: indirect and indexed have their own steps,
  // autoincrement and long indexed cost one more, memory adds memAdd to indirect and indexed only
  function automatic logic [7:0] timeOf(
    input logic [7:0] base,
    input logic [7:0] immAdd,
    input logic [7:0] indAdd,
    input logic [7:0] idxAdd,
    input logic [7:0] memAdd,
    input ilot_pkg::ilot_mode_e m,
    input logic mem
  );
    logic [7:0] t;
    t = base;
    unique case (m)
      ilot_pkg::ILOT_MODE_IMMED: t = base + immAdd;
      ilot_pkg::ILOT_MODE_IND: t = base + indAdd;
      ilot_pkg::ILOT_MODE_IND_AUTO: t = base + indAdd + ilot_pkg::T_ONE;
      ilot_pkg::ILOT_MODE_IDX_S: t = base + idxAdd;
      ilot_pkg::ILOT_MODE_IDX_L: t = base + idxAdd + ilot_pkg::T_ONE;
      default: t = base;
    endcase
    if (mem && m != ilot_pkg::ILOT_MODE_DIRECT
        && m != ilot_pkg::ILOT_MODE_IMMED) begin
      t = t + memAdd;
    end
    timeOf = t;
  endfunction : timeOf

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    ilot_pkg::ilot_mode_e m;
    logic [2:0] baseLen;
    m = modeOf(core[1:0], modeByte[0]);
    baseLen = ilot_pkg::LEN_3;
    state_d = state_q;
    state_d.valid = 1'b0;
    if (reqValid) begin
      state_d.valid = 1'b1;
      state_d.st = ilot_pkg::ILOT_ST_DONE;
      state_d.rsp = '0;
      state_d.rsp.mode = ilot_pkg::ILOT_MODE_NONE;
      state_d.rsp.known = 1'b1;
      state_d.rsp.wordReg = modeByte[7:1];
      if (shortRel) begin
        // short relative jump and call
        state_d.rsp.length = ilot_pkg::LEN_2;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_REL;
        state_d.rsp.relOffset = offset;
        state_d.rsp.isJump = (core[3] == 1'b0);
        state_d.rsp.isCall = core[3];
        state_d.rsp.stateTimes = ilot_pkg::T_SHORT_RELATIVE_JUMP;
      end else if (core[7:4] == ilot_pkg::OP_JBC_LO[7:4]) begin
        // bit test jumps
        state_d.rsp.length = ilot_pkg::LEN_3;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_IDX_S;
        state_d.rsp.isJump = 1'b1;
        state_d.rsp.relOffset = {{3{req.b2[7]}}, req.b2};
        state_d.rsp.stateTimes = ilot_pkg::T_BIT_NT
          + (req.condTrue ? ilot_pkg::T_TAKEN_ADD : '0);
      end else if (core[7:4] == ilot_pkg::OP_COND_LO[7:4]) begin
        // flag jumps
        state_d.rsp.length = ilot_pkg::LEN_2;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_IDX_S;
        state_d.rsp.isJump = 1'b1;
        state_d.rsp.relOffset = offset;
        state_d.rsp.stateTimes = ilot_pkg::T_COND_NT
          + (req.condTrue ? ilot_pkg::T_TAKEN_ADD : '0);
      end else if (core == ilot_pkg::OP_DECREMENT_BYTE_BRANCH_NONZERO
                   || core == ilot_pkg::OP_DECREMENT_WORD_BRANCH_NONZERO) begin
        state_d.rsp.length = ilot_pkg::LEN_3;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_IDX_S;
        state_d.rsp.isJump = 1'b1;
        state_d.rsp.relOffset = {{3{req.b2[7]}}, req.b2};
        state_d.rsp.stateTimes =
          (core[0] ? ilot_pkg::T_DECREMENT_WORD_BRANCH_NONZERO_NT : ilot_pkg::T_BIT_NT)
          + (req.condTrue ? ilot_pkg::T_TAKEN_ADD : '0);
      end else if (core == ilot_pkg::OP_IBR) begin
        state_d.rsp.length = ilot_pkg::LEN_2;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_IND;
        state_d.rsp.isJump = 1'b1;
        state_d.rsp.wideBranch = req.wideSpace;
        state_d.rsp.stateTimes = req.wideSpace ? ilot_pkg::T_EBR
                                               : ilot_pkg::T_IBR;
      end else if (core == ilot_pkg::OP_BLOCK_WORD_MOVE) begin
        state_d.rsp.length = ilot_pkg::LEN_3;
        state_d.rsp.mode = ilot_pkg::ILOT_MODE_IND;
        state_d.rsp.stateTimes = ilot_pkg::T_BLOCK_WORD_MOVE;
        unique case (req.blockKind)
          2'b00: state_d.rsp.perWord = ilot_pkg::T_BLOCK_WORD_MOVE_RR;
          2'b01: state_d.rsp.perWord = ilot_pkg::T_BLOCK_WORD_MOVE_MR;
          default: state_d.rsp.perWord = ilot_pkg::T_BLOCK_WORD_MOVE_MM;
        endcase
      end else begin
        // operand groups with four addressing modes
        state_d.rsp.mode = m;
        if (m == ilot_pkg::ILOT_MODE_IDX_S
            || m == ilot_pkg::ILOT_MODE_IMMED) begin
          baseLen = ilot_pkg::LEN_3 + ilot_pkg::LEN_1;
        end else if (m == ilot_pkg::ILOT_MODE_IDX_L) begin
          baseLen = ilot_pkg::LEN_3 + ilot_pkg::LEN_2;
        end
        state_d.rsp.length = baseLen
          + (prefixed ? ilot_pkg::LEN_1 : '0);
        unique case ({core[7:2], 2'b00})
          ilot_pkg::OP_ADD2: state_d.rsp.stateTimes = timeOf(
            ilot_pkg::T_ADD, ilot_pkg::T_ONE, ilot_pkg::T_TWO,
            ilot_pkg::T_TWO, ilot_pkg::T_TWO, m,
            req.memOperand);
          ilot_pkg::OP_MULU2: state_d.rsp.stateTimes = timeOf(
            ilot_pkg::T_MUL, ilot_pkg::T_ONE, ilot_pkg::T_TWO,
            ilot_pkg::T_THREE, ilot_pkg::T_THREE, m,
            req.memOperand);
          ilot_pkg::OP_UNSIGNED_WORD_DIVIDE: state_d.rsp.stateTimes = timeOf(
            prefixed ? ilot_pkg::T_DIV : ilot_pkg::T_UNSIGNED_WORD_DIVIDE,
            ilot_pkg::T_ONE, ilot_pkg::T_TWO, ilot_pkg::T_THREE,
            ilot_pkg::T_THREE, m, req.memOperand);
          ilot_pkg::OP_LOAD_BYTE_ZERO_EXTEND: begin
            state_d.rsp.stateTimes = timeOf(ilot_pkg::T_LOAD_BYTE_ZERO_EXTEND, '0,
              ilot_pkg::T_ONE, ilot_pkg::T_TWO, ilot_pkg::T_THREE, m,
              req.memOperand);
            // autoincrement from memory costs no more than plain indirect
            if (m == ilot_pkg::ILOT_MODE_IND_AUTO && req.memOperand) begin
              state_d.rsp.stateTimes = ilot_pkg::T_LOAD_BYTE_ZERO_EXTEND + ilot_pkg::T_FOUR;
            end
            if (m == ilot_pkg::ILOT_MODE_IMMED) begin
              state_d.rsp.length = ilot_pkg::LEN_3;
            end
          end
          default: begin
            state_d.rsp.known = 1'b0;
            state_d.rsp.stateTimes = '0;
          end
        endcase
      end
    end
    if (!clkEn) begin
      state_d = state_q;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '{st: ilot_pkg::ILOT_ST_IDLE, valid: 1'b0,
                   rsp: '{mode: ilot_pkg::ILOT_MODE_NONE, default: '0}};
    end else begin
      state_q <= state_d;
    end
  end

  assign rspValid = state_q.valid;
  assign rsp = state_q.rsp;
endmodule : ilot_decoder

// ===== shared/ilot_pkg.sv
// shared constants and carriers for the instruction length and timing decoder
package ilot_pkg;
  // addressing modes
  typedef enum logic [7:0] {
    ILOT_MODE_NONE     = 8'b0000_0001,
    ILOT_MODE_DIRECT   = 8'b0000_0010,
    ILOT_MODE_IMMED    = 8'b0000_0100,
    ILOT_MODE_IND      = 8'b0000_1000,
    ILOT_MODE_IND_AUTO = 8'b0001_0000,
    ILOT_MODE_IDX_S    = 8'b0010_0000,
    ILOT_MODE_IDX_L    = 8'b0100_0000,
    ILOT_MODE_REL      = 8'b1000_0000
  } ilot_mode_e;

  // decoder state
  typedef enum logic [1:0] {
    ILOT_ST_IDLE = 2'b01,
    ILOT_ST_DONE = 2'b10
  } ilot_state_e;

  // request: up to three bytes of an instruction
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic memOperand;
    logic wideSpace;
    logic condTrue;
    logic [1:0] blockKind;
  } ilot_req_s;

  // answer
  typedef struct packed {
    logic [2:0] length;
    ilot_mode_e mode;
    logic [7:0] stateTimes;
    logic [7:0] perWord;
    logic [10:0] relOffset;
    logic [6:0] wordReg;
    logic isJump;
    logic isCall;
    logic wideBranch;
    logic known;
  } ilot_rsp_s;

  // opcode constants
  localparam logic [7:0] OP_PREFIX = 8'hFE;
  localparam logic [7:0] OP_SHORT_RELATIVE_JUMP_LO = 8'h20;
  localparam logic [7:0] OP_SHORT_RELATIVE_CALL_LO = 8'h28;
  localparam logic [7:0] OP_JBC_LO = 8'h30;
  localparam logic [7:0] OP_JBS_LO = 8'h38;
  localparam logic [7:0] OP_COND_LO = 8'hD0;
  localparam logic [7:0] OP_DECREMENT_BYTE_BRANCH_NONZERO = 8'hE0;
  localparam logic [7:0] OP_DECREMENT_WORD_BRANCH_NONZERO = 8'hE1;
  localparam logic [7:0] OP_IBR = 8'hE3;
  localparam logic [7:0] OP_BLOCK_WORD_MOVE = 8'hC1;
  localparam logic [7:0] OP_ADD2 = 8'h64;
  localparam logic [7:0] OP_MULU2 = 8'h6C;
  localparam logic [7:0] OP_UNSIGNED_WORD_DIVIDE = 8'h8C;
  localparam logic [7:0] OP_LOAD_BYTE_ZERO_EXTEND = 8'hAC;
  localparam logic [5:0] GRP_MASK = 6'h3F;

  // lengths
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;

  // state time bases (direct operand) and offsets
  localparam logic [7:0] T_ADD = 8'h04;
  localparam logic [7:0] T_MUL = 8'h10;
  localparam logic [7:0] T_UNSIGNED_WORD_DIVIDE = 8'h18;
  localparam logic [7:0] T_DIV = 8'h1A;
  localparam logic [7:0] T_LOAD_BYTE_ZERO_EXTEND = 8'h04;
  localparam logic [7:0] T_BLOCK_WORD_MOVE = 8'h06;
  localparam logic [7:0] T_BLOCK_WORD_MOVE_RR = 8'h08;
  localparam logic [7:0] T_BLOCK_WORD_MOVE_MR = 8'h0B;
  localparam logic [7:0] T_BLOCK_WORD_MOVE_MM = 8'h0E;
  localparam logic [7:0] T_SHORT_RELATIVE_JUMP = 8'h07;
  localparam logic [7:0] T_COND_NT = 8'h04;
  localparam logic [7:0] T_BIT_NT = 8'h05;
  localparam logic [7:0] T_DECREMENT_WORD_BRANCH_NONZERO_NT = 8'h06;
  localparam logic [7:0] T_TAKEN_ADD = 8'h04;
  localparam logic [7:0] T_IBR = 8'h07;
  localparam logic [7:0] T_EBR = 8'h09;
  localparam logic [7:0] T_ONE = 8'h01;
  localparam logic [7:0] T_TWO = 8'h02;
  localparam logic [7:0] T_THREE = 8'h03;
  localparam logic [7:0] T_FOUR = 8'h04;
  localparam logic [7:0] T_FIVE = 8'h05;
endpackage : ilot_pkg

// ===== src/ilot_offset.sv
// relative offset former for short and conditional jumps
`timescale 1ns/100ps
module ilot_offset (
  input wire logic [7:0] op,
  input wire logic [7:0] disp,
  input wire logic isShort,
  output logic [10:0] offset
);
  // short form joins three opcode bits with the byte, else sign-extend byte
  always_comb begin
    if (isShort) begin
      offset = {op[2:0], disp};
    end else begin
      offset = {{3{disp[7]}}, disp};
    end
  end
endmodule : ilot_offset

// ===== testbench/ilot_decoder_props.sv
// checker for the instruction length and timing decoder
`timescale 1ns/100ps
module ilot_decoder_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire ilot_pkg::ilot_req_s req,
  input wire logic rspValid,
  input wire ilot_pkg::ilot_rsp_s rsp
);
  ilot_pkg::ilot_req_s reqQ;
  logic take;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  assign take = clkEn && reqValid;
  // remember the request that the current answer belongs to
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqQ <= '0;
    end else if (take) begin
      reqQ <= req;
    end
  end
  // ----------------------------------------
  // handshake and decode relations
  // ----------------------------------------
  answer_pulse_a: assert property (take |=> rspValid)
    else $error("no answer one cycle after a taken request");
  idle_quiet_a: assert property (clkEn && !reqValid |=> !rspValid)
    else $error("answer without a request");
  freeze_hold_a: assert property
    (!clkEn |=> $stable(rsp) && $stable(rspValid))
    else $error("outputs moved while clock enable was low");
  short_offset_a: assert property (rspValid && reqQ.op[7:4] == 4'h2 |->
    rsp.relOffset == {reqQ.op[2:0], reqQ.b1} && rsp.length == 3'h2)
    else $error("short jump offset or length wrong");
  auto_select_a: assert property (rspValid && reqQ.op == 8'h66 |->
    rsp.wordReg == reqQ.b1[7:1] && rsp.mode == (reqQ.b1[0] ?
    ilot_pkg::ILOT_MODE_IND_AUTO : ilot_pkg::ILOT_MODE_IND))
    else $error("indirect form not chosen by second byte");
  long_index_a: assert property (rspValid && reqQ.op == 8'h67 |->
    rsp.length == 3'h4 + 3'(reqQ.b1[0]))
    else $error("indexed length not chosen by second byte");
  add_timing_a: assert property (rspValid && reqQ.op == 8'h66 |->
    rsp.stateTimes == 8'h06 + 8'({reqQ.memOperand, reqQ.b1[0]}))
    else $error("indirect add state times wrong");
  bit_jump_a: assert property (rspValid && reqQ.op[7:4] == 4'h3 |->
    rsp.length == 3'h3)
    else $error("bit jump length wrong");
  word_decr_a: assert property (rspValid && reqQ.op == 8'hE1 |->
    rsp.length == 3'h3 && rsp.stateTimes == (reqQ.condTrue ? 8'h0A : 8'h06))
    else $error("word decrement branch wrong");
  flag_sext_a: assert property (rspValid && reqQ.op[7:4] == 4'hD |->
    rsp.relOffset == {{3{reqQ.b1[7]}}, reqQ.b1} && rsp.length == 3'h2)
    else $error("flag jump displacement not sign extended");
  wide_branch_a: assert property (rspValid && reqQ.op == 8'hE3 |->
    rsp.wideBranch == reqQ.wideSpace &&
    rsp.stateTimes == (reqQ.wideSpace ? 8'h09 : 8'h07))
    else $error("indirect branch space wrong");
  signed_div_a: assert property (rspValid && reqQ.op == 8'hFE &&
    reqQ.b1 == 8'h8C |-> rsp.length == 3'h4 && rsp.stateTimes == 8'h1A)
    else $error("prefixed divide wrong");
  block_move_a: assert property (rspValid && reqQ.op == 8'hC1 |->
    rsp.stateTimes == 8'h06 && rsp.perWord == (reqQ.blockKind == 2'h0 ?
    8'h08 : (reqQ.blockKind == 2'h1 ? 8'h0B : 8'h0E)))
    else $error("block move timing wrong");
  prefix_seen_c: cover property (take && req.op == 8'hFE);
  frozen_seen_c: cover property (!clkEn && rspValid);
  short_seen_c: cover property (rspValid && reqQ.op[7:4] == 4'h2);
endmodule : ilot_decoder_props
bind ilot_decoder ilot_decoder_props i_ilot_decoder_props (.clk(clk),
  .rst_b(rst_b), .clkEn(clkEn), .reqValid(reqValid), .req(req),
  .rspValid(rspValid), .rsp(rsp));

// ===== testbench/ilot_decoder_tb.sv
// self-checking bench for the instruction length and timing decoder
`timescale 1ns/100ps
module ilot_decoder_tb;
  logic clk;
  logic rst_b;
  logic clkEn;
  logic reqValid;
  ilot_pkg::ilot_req_s req;
  ilot_pkg::ilot_req_s r;
  logic rspValid;
  ilot_pkg::ilot_rsp_s rsp;
  ilot_pkg::ilot_rsp_s held;
  int n_fail;
  int comparisons;
  logic [7:0] bases [0:10] = '{8'h64, 8'hAC, 8'h8C, 8'hFE, 8'hFE, 8'h20,
    8'h30, 8'hD0, 8'hE0, 8'hE3, 8'hC1};
  logic [7:0] masks [0:10] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h0F,
    8'h0F, 8'h0F, 8'h01, 8'h00, 8'h00};
  ilot_decoder i_ilot_decoder (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .reqValid(reqValid), .req(req), .rspValid(rspValid), .rsp(rsp));
  // free-running state clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // expectation and checking helpers
  // ----------------------------------------
  // picks a time from a direct..long-memory row of ten figures
  function automatic logic [7:0] pick(input logic [1:0] lo, input logic odd,
      input logic mem, input logic [79:0] t);
    int i;
    i = (lo < 2) ? lo : 2 + 4 * (lo - 2) + 2 * odd + mem;
    return t[79 - 8 * i -: 8];
  endfunction : pick
  function automatic ilot_pkg::ilot_rsp_s exp_of(input ilot_pkg::ilot_req_s q);
    ilot_pkg::ilot_rsp_s e;
    logic pre;
    logic [7:0] op;
    logic [7:0] mb;
    logic [79:0] t;
    e = '0;
    pre = q.op == 8'hFE;
    op = pre ? q.b1 : q.op;
    mb = pre ? q.b2 : q.b1;
    case (op[7:2])
      6'h19: t = 80'h0405_0608_0709_0608_0709;
      6'h2B: t = 80'h0404_0508_0608_0609_070A;
      6'h23: t = pre ? 80'h1A1B_1C1F_1D20_1D20_1E21
        : 80'h1819_1A1D_1B1E_1B1E_1C1F;
      6'h1B: t = 80'h1011_1215_1316_1316_1417;
      default: t = '0;
    endcase
    if (t != '0) begin
      e.known = 1'b1;
      e.stateTimes = pick(op[1:0], mb[0], q.memOperand, t);
      e.wordReg = mb[7:1];
      e.mode = ilot_pkg::ilot_mode_e'(8'h01 << (op[1] ? 2 * op[1:0] - 1 + mb[0]
        : op[1:0] + 1));
      e.length = 3'h3 + 3'(pre) + 3'(op[1:0] == 2'h1 && op[7:2] != 6'h2B)
        + (op[1:0] == 2'h3 ? 3'h1 + 3'(mb[0]) : 3'h0);
    end else if (q.op[7:4] == 4'h2) begin
      e.length = 3'h2;
      e.mode = ilot_pkg::ILOT_MODE_REL;
      e.stateTimes = 8'h07;
      e.relOffset = {q.op[2:0], q.b1};
      e.isCall = q.op[3];
      e.isJump = !q.op[3];
    end else if (q.op[7:4] == 4'h3 || q.op[7:1] == 7'h70) begin
      e.length = 3'h3;
      e.mode = ilot_pkg::ILOT_MODE_IDX_S;
      e.isJump = 1'b1;
      e.stateTimes = (q.op == 8'hE1 ? 8'h06 : 8'h05) + (q.condTrue ? 8'h04 : 8'h00);
      e.relOffset = {{3{q.b2[7]}}, q.b2};
    end else if (q.op[7:4] == 4'hD) begin
      e.length = 3'h2;
      e.mode = ilot_pkg::ILOT_MODE_IDX_S;
      e.isJump = 1'b1;
      e.stateTimes = q.condTrue ? 8'h08 : 8'h04;
      e.relOffset = {{3{q.b1[7]}}, q.b1};
    end else if (q.op == 8'hE3) begin
      e.length = 3'h2;
      e.mode = ilot_pkg::ILOT_MODE_IND;
      e.isJump = 1'b1;
      e.stateTimes = q.wideSpace ? 8'h09 : 8'h07;
      e.wideBranch = q.wideSpace;
    end else begin
      e.length = 3'h3;
      e.mode = ilot_pkg::ILOT_MODE_IND;
      e.stateTimes = 8'h06;
      e.perWord = q.blockKind == 2'h0 ? 8'h08 : (q.blockKind == 2'h1 ? 8'h0B : 8'h0E);
    end
    return e;
  endfunction : exp_of
  task automatic chk(input string nm, input logic [10:0] ex, input logic [10:0] got);
    comparisons++;
    if (got !== ex) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic check_rsp(input ilot_pkg::ilot_req_s q);
    ilot_pkg::ilot_rsp_s e;
    e = exp_of(q);
    chk("valid", 11'h001, 11'(rspValid));
    chk("length", 11'(e.length), 11'(rsp.length));
    chk("time", 11'(e.stateTimes), 11'(rsp.stateTimes));
    chk("known", 11'h001, 11'(rsp.known));
    chk("jump", 11'(e.isJump), 11'(rsp.isJump));
    if (e.relOffset !== 11'h000 || q.op[7:4] == 4'h2) begin
      chk("offset", e.relOffset, rsp.relOffset);
    end
    if (q.op[7:4] == 4'h2) chk("call", 11'(e.isCall), 11'(rsp.isCall));
    if (q.op == 8'hC1) chk("per word", 11'(e.perWord), 11'(rsp.perWord));
    if (q.op == 8'hE3) chk("wide", 11'(e.wideBranch), 11'(rsp.wideBranch));
    chk("mode", 11'(e.mode), 11'(rsp.mode));
    if (e.known) chk("word reg", 11'(e.wordReg), 11'(rsp.wordReg));
  endtask : check_rsp
  // presents one request at a falling edge and checks the answer
  task automatic send(input ilot_pkg::ilot_req_s q);
    req = q;
    reqValid = 1'b1;
    @(negedge clk);
    check_rsp(q);
  endtask : send
  task automatic rand_req(output ilot_pkg::ilot_req_s q);
    int f;
    q = 29'($urandom);
    f = $urandom_range(10);
    q.op = bases[f] | (q.op & masks[f]);
    if (f == 3) q.b1 = 8'h8C | (q.b1 & 8'h03);
    if (f == 4) q.b1 = 8'h6C | (q.b1 & 8'h03);
  endtask : rand_req
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    comparisons = 0;
    clkEn = 1'b1;
    reqValid = 1'b0;
    req = '0;
    rst_b = 1'b0;
    void'($urandom(4));
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    send('{8'h27, 8'hFF, 8'h00, 1'b0, 1'b0, 1'b0, 2'h0});
    send('{8'h28, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 2'h0});
    send('{8'hD7, 8'h80, 8'h00, 1'b0, 1'b0, 1'b1, 2'h0});
    send('{8'hFE, 8'h8F, 8'h03, 1'b1, 1'b0, 1'b0, 2'h0});
    send('{8'hFE, 8'h6E, 8'h05, 1'b1, 1'b0, 1'b0, 2'h0});
    send('{8'h67, 8'hFF, 8'h00, 1'b1, 1'b0, 1'b0, 2'h0});
    send('{8'hE1, 8'h10, 8'h80, 1'b0, 1'b0, 1'b1, 2'h0});
    send('{8'hC1, 8'h20, 8'h30, 1'b0, 1'b0, 1'b0, 2'h3});
    send('{8'hE3, 8'h20, 8'h00, 1'b0, 1'b1, 1'b0, 2'h0});
    send('{8'h66, 8'h20, 8'h00, 1'b0, 1'b0, 1'b0, 2'h0});
    send('{8'hAE, 8'h20, 8'h00, 1'b1, 1'b0, 1'b0, 2'h0});
    send('{8'hAF, 8'h21, 8'h00, 1'b1, 1'b0, 1'b0, 2'h0});
    repeat (400) begin
      rand_req(r);
      send(r);
    end
    held = rsp;
    clkEn = 1'b0;
    rand_req(r);
    req = r;
    repeat (3) @(negedge clk);
    chk("frozen valid", 11'h001, 11'(rspValid));
    chk("frozen time", 11'(held.stateTimes), 11'(rsp.stateTimes));
    clkEn = 1'b1;
    reqValid = 1'b0;
    @(negedge clk);
    chk("idle valid", 11'h000, 11'(rspValid));
    send('{8'h8E, 8'h20, 8'h00, 1'b0, 1'b0, 1'b0, 2'h0});
    // reset while an answer stands, so that clearing it shows
    rst_b = 1'b0;
    reqValid = 1'b0;
    #1;
    chk("reset valid", 11'h000, 11'(rspValid));
    chk("reset time", 11'h000, 11'(rsp.stateTimes));
    chk("reset mode", 11'(ilot_pkg::ILOT_MODE_NONE), 11'(rsp.mode));
    @(negedge clk);
    rst_b = 1'b1;
    send('{8'h66, 8'h41, 8'h00, 1'b1, 1'b0, 1'b0, 2'h0});
    reqValid = 1'b0;
    close_out;
  end
  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out;
  end
endmodule : ilot_decoder_tb
